// *** rtl/pcd_clock_divider_control.sv ***
// Purpose: digital control of a programmable graphics clock synthesizer
// Assumes: pclk stands in for the vco; vco = pclk/2, all divided clocks are flop levels
// Notes:   nibble and serial programming pins are asynchronous and pass three flops
`timescale 1ns/10ps
`include "pcd_map.svh"

module pcd_clock_divider_control
    import pcd_pkg::*;
(
    input  wire logic        pclk,         // system and vco stand-in clock
    input  wire logic        presetn,      // async reset, power-on
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb access phase
    input  wire logic        pwrite,       // apb direction
    input  wire logic [11:0] paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error on unmapped address
    input  wire logic [3:0]  nibble_bus,   // parallel address/data nibble
    input  wire logic        nibble_latch, // parallel strobe
    input  wire logic        serial_shift_clock, // serial bit clock
    input  wire logic        serial_data,  // serial bit
    input  wire logic        transfer_hold, // serial transfer request
    input  wire logic        video_gate,   // gate for detector or shift clock
    input  wire logic        ref_clk_in,   // reference oscillator level
    output logic             pixel_clk_p,  // differential pixel clock, true
    output logic             pixel_clk_n,  // differential pixel clock, complement
    output logic             load_clk,     // pixel-group clock
    output logic             secondary_divided_output, // second divider output
    output logic             ref_div_tick, // reference divider terminal pulse
    output logic             fb_div_tick,  // feedback divider terminal pulse
    output logic             detector_enable, // phase detector may lock
    output logic             pipeline_reset_busy // reset sequence running
);

    pcd_state_type q;
    pcd_state_type d;
    logic [3:0]    hold_q [16];
    logic          par_we;
    logic          ser_we;

    //////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] pcd_n1_mod(input logic [3:0] code);
        logic [4:0] m;
        case (code)
            4'h0:    m = 5'h03;
            4'h1:    m = 5'h04;
            4'h2:    m = 5'h05;
            4'h3:    m = 5'h06;
            4'h4:    m = 5'h08;
            4'h5:    m = 5'h0A;
            4'h6:    m = 5'h0C;
            4'h7:    m = 5'h10;
            4'h8:    m = 5'h14;
            default: m = 5'h04;
        endcase
        return m;
    endfunction

    function automatic logic pcd_rise(input logic now, input logic nxt);
        return !now && nxt;
    endfunction

    // output latches: power-on values until unlocked, then transparent
    function automatic logic [3:0] act(input logic [3:0] idx);
        logic [3:0] v;
        v = 4'h0;
        if (q.unlocked) begin
            v = hold_q[idx];
        end else if (idx == `PCD_REG_N1) begin
            v = `PCD_POR_N1_CODE;
        end
        return v;
    endfunction

    //////////////////////////////////////////////////////////////////////////////////////
    logic [6:0] cfg_ref_m1;
    logic [8:0] cfg_fb_n;
    logic       cfg_double;
    logic [1:0] cfg_ps_sel;
    logic       cfg_static;
    logic       cfg_vhalf;
    logic [3:0] cfg_n1_code;
    logic       cfg_n1_off;
    logic       cfg_prst;
    logic       cfg_dgate;
    logic       cfg_scgate;
    logic [8:0] cfg_n2_m1;
    logic [3:0] act_v [16];

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            act_v[i] = act(4'(i));
        end
        cfg_ref_m1  = {act_v[`PCD_REG_REF_HI][2:0], act_v[`PCD_REG_REF_LO]};
        cfg_fb_n    = {act_v[`PCD_REG_FB_HI][0], act_v[`PCD_REG_FB_MID], act_v[`PCD_REG_FB_LO]};
        cfg_double  = act_v[`PCD_REG_FB_HI][`PCD_FB_DOUBLE];
        cfg_ps_sel  = act_v[`PCD_REG_POST][1:0];
        cfg_static  = act_v[`PCD_REG_POST][`PCD_POST_STATIC];
        cfg_vhalf   = act_v[`PCD_REG_POST][`PCD_POST_VHALF];
        cfg_n1_code = act_v[`PCD_REG_N1];
        cfg_n1_off  = act_v[`PCD_REG_CTL][`PCD_CTL_N1_OFF];
        cfg_prst    = act_v[`PCD_REG_CTL][`PCD_CTL_PRST];
        cfg_dgate   = act_v[`PCD_REG_CTL][`PCD_CTL_DGATE];
        cfg_scgate  = act_v[`PCD_REG_CTL][`PCD_CTL_SCGATE];
        cfg_n2_m1   = {act_v[`PCD_REG_N2_HI][0], act_v[`PCD_REG_N2_MID], act_v[`PCD_REG_N2_LO]};
    end

    //////////////////////////////////////////////////////////////////////////////////////
    logic       latch_rise;
    logic       latch_fall;
    logic       sclk_rise;
    logic       ref_rise;
    logic       ps_now;
    logic       ps_nxt;
    logic       ps_edge;
    logic       load_nxt;
    logic       load_edge;
    logic       gate_lvl;
    logic [9:0] fb_term_new;
    logic       apb_wr;

    always_comb begin
        d = q;
        par_we = 1'b0;
        ser_we = 1'b0;

        // three-flop synchronisers; a change counts when stages two and three agree
        d.s1 = {ref_clk_in, video_gate, transfer_hold, serial_data, serial_shift_clock,
                nibble_bus, nibble_latch};
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < `PCD_IN_WIDTH; i++) begin
            d.filt[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.filt[i];
        end
        latch_rise = pcd_rise(q.filt[`PCD_IN_LATCH], d.filt[`PCD_IN_LATCH]);
        latch_fall = pcd_rise(d.filt[`PCD_IN_LATCH], q.filt[`PCD_IN_LATCH]);
        sclk_rise  = pcd_rise(q.filt[`PCD_IN_SCLK], d.filt[`PCD_IN_SCLK]);
        ref_rise   = pcd_rise(q.filt[`PCD_IN_REF], d.filt[`PCD_IN_REF]);

        // parallel programming port
        if (!q.serial_mode) begin
            if (latch_fall) begin
                d.addr = d.filt[`PCD_IN_NIB_LO +: 4];
            end
            if (latch_rise) begin
                // 13 and 14 have no storage but still count toward unlock
                par_we = (q.addr != `PCD_REG_VOID_A) && (q.addr != `PCD_REG_VOID_B);
                if (q.wr_cnt != `PCD_UNLOCK_WRITES) begin
                    d.wr_cnt = q.wr_cnt + 6'h01;
                end
                if (d.wr_cnt == `PCD_UNLOCK_WRITES) begin
                    d.unlocked = 1'b1;
                end
            end
        end else if (sclk_rise) begin
            // serial port: shift and hold share one synchroniser so they stay aligned
            d.shift = {q.shift[62:0], d.filt[`PCD_IN_SDATA]};
            if (d.filt[`PCD_IN_HOLD]) begin
                ser_we     = 1'b1;
                d.unlocked = 1'b1;
            end
        end

        // free-running vco divisions: bit0 vco, bit1 half, bit2 quarter
        d.free = q.free + 3'h1;
        if (d.free == 3'h0) begin
            d.ps_sel = cfg_ps_sel;
        end
        ps_now = (q.ps_sel == 2'h3) ? cfg_static : q.free[q.ps_sel];
        ps_nxt = (d.ps_sel == 2'h3) ? cfg_static : d.free[d.ps_sel];
        ps_edge = ps_now != ps_nxt;
        d.pix = q.unlocked ? ps_nxt : d.filt[`PCD_IN_REF];

        // first divider counts both post-scaler edges, so odd moduli stay 50/50
        load_nxt = q.load;
        if (ps_edge) begin
            if (q.n1_cnt >= q.n1_mod - 5'h01) begin
                d.n1_cnt = 5'h00;
                d.n1_mod = pcd_n1_mod(cfg_n1_code);
                if (q.prst_cnt != 4'h0) begin
                    d.prst_cnt = q.prst_cnt - 4'h1;
                    load_nxt   = 1'b0;
                end else begin
                    load_nxt = !q.load;
                end
            end else begin
                d.n1_cnt = q.n1_cnt + 5'h01;
            end
        end
        // wait for a low phase before forcing, so no runt high pulse is cut
        if (cfg_n1_off && !q.load) begin
            load_nxt = 1'b0;
        end
        if (cfg_vhalf && (!q.load || q.free[1])) begin
            load_nxt = d.free[1];
        end
        d.load = load_nxt;
        load_edge = q.load != load_nxt;

        // pipeline reset: arm on the falling edge of the control bit
        d.prst_old = cfg_prst;
        if (q.prst_old && !cfg_prst && (cfg_n1_code <= 4'h5)) begin
            d.prst_cnt = `PCD_PRST_HALVES;
        end

        // second divider, optionally gated by the video gate
        gate_lvl = d.filt[`PCD_IN_VGATE];
        if (load_edge) begin
            if (cfg_scgate && !gate_lvl && !load_nxt) begin
                d.sec     = 1'b0;
                d.sec_run = 1'b0;
                d.n2_cnt  = 9'h000;
            end else if (!q.sec_run) begin
                if (load_nxt && (!cfg_scgate || gate_lvl)) begin
                    d.sec_run = 1'b1;
                    d.sec     = 1'b1;
                    d.n2_cnt  = 9'h000;
                    d.n2_m1   = cfg_n2_m1;
                end
            end else if (q.n2_cnt >= q.n2_m1) begin
                d.sec    = !q.sec;
                d.n2_cnt = 9'h000;
                d.n2_m1  = cfg_n2_m1;
            end else begin
                d.n2_cnt = q.n2_cnt + 9'h001;
            end
        end

        // reference divider, one tick per modulus reference edges
        d.ref_tick = 1'b0;
        if (ref_rise) begin
            if (q.ref_cnt >= q.ref_m1) begin
                d.ref_cnt  = 7'h00;
                d.ref_m1   = cfg_ref_m1;
                d.ref_tick = 1'b1;
            end else begin
                d.ref_cnt = q.ref_cnt + 7'h01;
            end
        end

        // feedback divider on vco rising edges; prescaler folded into one counter
        fb_term_new = cfg_double ? {cfg_fb_n, 1'b0} - 10'h001
                                 : {1'b0, cfg_fb_n} - 10'h001;
        d.fb_tick = 1'b0;
        if (pcd_rise(q.free[0], d.free[0])) begin
            if (q.fb_cnt >= q.fb_term) begin
                d.fb_cnt  = 10'h000;
                d.fb_term = fb_term_new;
                d.fb_tick = 1'b1;
            end else begin
                d.fb_cnt = q.fb_cnt + 10'h001;
            end
        end

        // the video gate serves the shift clock or the detector, never both
        if (q.serial_mode) begin
            d.det_en = !(cfg_dgate && !cfg_scgate && gate_lvl);
        end else begin
            d.det_en = !(cfg_dgate && (q.addr == `PCD_REG_GATE)
                         && d.filt[`PCD_IN_NIB_LO + 3]);
        end

        // apb slave, zero wait states, read data captured in setup
        apb_wr = psel && penable && pwrite && (paddr == `PCD_ADDR_CTRL);
        if (apb_wr) begin
            d.serial_mode = pwdata[`PCD_CTRL_SERIAL];
        end
        if (psel && !penable) begin
            d.prdata = 32'h0000_0000;
            if (paddr == `PCD_ADDR_CTRL) begin
                d.prdata[`PCD_CTRL_SERIAL] = q.serial_mode;
            end else if (paddr == `PCD_ADDR_STATUS) begin
                d.prdata[15:0] = {q.det_en, q.prst_cnt != 4'h0, q.sec, q.load,
                                  q.addr, q.unlocked, q.wr_cnt, 1'b0};
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q        <= '0;
            q.n1_mod <= `PCD_POR_N1_MOD;
            q.det_en <= 1'b1;
            // strobe pin idles high; starting low would fake a write after reset
            q.s1[`PCD_IN_LATCH]   <= 1'b1;
            q.s2[`PCD_IN_LATCH]   <= 1'b1;
            q.s3[`PCD_IN_LATCH]   <= 1'b1;
            q.filt[`PCD_IN_LATCH] <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // holding registers carry no reset on purpose; unwritten ones come up random
    always_ff @(posedge pclk) begin
        if (ser_we) begin
            for (int i = 0; i < 16; i++) begin
                hold_q[i] <= d.shift[4*i +: 4];
            end
        end else if (par_we) begin
            hold_q[q.addr] <= d.filt[`PCD_IN_NIB_LO +: 4];
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    assign prdata                   = q.prdata;
    assign pready                   = 1'b1;
    assign pslverr                  = psel && penable && (paddr != `PCD_ADDR_CTRL)
                                      && (paddr != `PCD_ADDR_STATUS);
    assign pixel_clk_p              = q.pix;
    assign pixel_clk_n              = !q.pix;
    assign load_clk                 = q.load;
    assign secondary_divided_output = q.sec;
    assign ref_div_tick             = q.ref_tick;
    assign fb_div_tick              = q.fb_tick;
    assign detector_enable          = q.det_en;
    assign pipeline_reset_busy      = q.prst_cnt != 4'h0;

endmodule

// *** rtl/pcd_map.svh ***
// Purpose: offsets, field positions, reset values and counts of the divider control
// Assumes: 32-bit APB, one register per aligned word
// Notes:   definitions only
`ifndef PCD_MAP_SVH
`define PCD_MAP_SVH

// apb register byte addresses
`define PCD_ADDR_CTRL       12'h000
`define PCD_ADDR_STATUS     12'h004
`define PCD_CTRL_SERIAL     0

// synchronised input vector positions
`define PCD_IN_WIDTH        10
`define PCD_IN_LATCH        0
`define PCD_IN_NIB_LO       1
`define PCD_IN_SCLK         5
`define PCD_IN_SDATA        6
`define PCD_IN_HOLD         7
`define PCD_IN_VGATE        8
`define PCD_IN_REF          9

// programming register numbers
`define PCD_REG_REF_LO      4'h0
`define PCD_REG_REF_HI      4'h1
`define PCD_REG_FB_LO       4'h2
`define PCD_REG_FB_MID      4'h3
`define PCD_REG_FB_HI       4'h4
`define PCD_REG_POST        4'h5
`define PCD_REG_N1          4'h6
`define PCD_REG_CTL         4'h7
`define PCD_REG_N2_LO       4'h8
`define PCD_REG_N2_MID      4'h9
`define PCD_REG_N2_HI       4'hB
`define PCD_REG_GATE        4'hF
`define PCD_REG_VOID_A      4'hD
`define PCD_REG_VOID_B      4'hE

// field positions inside the nibbles
`define PCD_FB_DOUBLE       1
`define PCD_POST_STATIC     2
`define PCD_POST_VHALF      3
`define PCD_CTL_N1_OFF      0
`define PCD_CTL_PRST        1
`define PCD_CTL_DGATE       2
`define PCD_CTL_SCGATE      3

// power-on values and counts
`define PCD_POR_N1_CODE     4'h1
`define PCD_POR_N1_MOD      5'h04
`define PCD_UNLOCK_WRITES   6'h20
`define PCD_PRST_HALVES     4'h8
`define PCD_SETTLE_US       500
`define PCD_CLK_MHZ         25
`define PCD_SETTLE_CYCLES   (`PCD_SETTLE_US * `PCD_CLK_MHZ)

`endif

// *** rtl/pcd_pkg.sv ***
// Purpose: types shared by the divider control
// Assumes: constants come from pcd_map.svh
// Notes:   the whole module state except the holding registers is one packed struct
package pcd_pkg;

    typedef struct packed {
        logic [9:0]  s1;
        logic [9:0]  s2;
        logic [9:0]  s3;
        logic [9:0]  filt;
        logic [3:0]  addr;
        logic [5:0]  wr_cnt;
        logic        unlocked;
        logic [63:0] shift;
        logic        serial_mode;
        logic [2:0]  free;
        logic [1:0]  ps_sel;
        logic        pix;
        logic        load;
        logic [4:0]  n1_cnt;
        logic [4:0]  n1_mod;
        logic        sec;
        logic        sec_run;
        logic [8:0]  n2_cnt;
        logic [8:0]  n2_m1;
        logic [6:0]  ref_cnt;
        logic [6:0]  ref_m1;
        logic        ref_tick;
        logic [9:0]  fb_cnt;
        logic [9:0]  fb_term;
        logic        fb_tick;
        logic        prst_old;
        logic [3:0]  prst_cnt;
        logic        det_en;
        logic [31:0] prdata;
    } pcd_state_type;

endpackage

// *** testbench/pcd_clock_divider_control_chk.sv ***
// Purpose: port checker of the divider control
// Assumes: pready tied high, vco is pclk/2
// Notes:   bound after the module
`timescale 1ns/10ps
module pcd_chk (
    input wire logic        pclk,               // clock
    input wire logic        presetn,            // reset, low
    input wire logic        psel,               // select
    input wire logic        penable,            // access
    input wire logic [11:0] paddr,              // address
    input wire logic        pready,             // ready
    input wire logic        pslverr,            // error
    input wire logic [3:0]  nibble_bus,         // nibble pins
    input wire logic        video_gate,         // gate pin
    input wire logic        pixel_clk_p,        // pixel true
    input wire logic        pixel_clk_n,        // pixel inverse
    input wire logic        load_clk,           // group clock
    input wire logic        ref_div_tick,       // ref terminal
    input wire logic        fb_div_tick,        // fb terminal
    input wire logic        detector_enable,    // lock allowed
    input wire logic        pipeline_reset_busy // sequence on
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_quiet;
        (!nibble_bus[3] && !video_gate) [*6];
    endsequence
    sequence s_busy2;
        pipeline_reset_busy [*2];
    endsequence
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err;
        pslverr == (psel && penable && paddr != 12'h000 && paddr != 12'h004);
    endproperty
    a_err: assert property (p_err) else $error("pslverr wrong");
    property p_diff;
        pixel_clk_n == !pixel_clk_p;
    endproperty
    a_diff: assert property (p_diff) else $error("pixel pair");
    property p_load_hi;
        $rose(load_clk) |=> load_clk;
    endproperty
    a_load_hi: assert property (p_load_hi) else $error("runt high");
    property p_load_lo;
        $fell(load_clk) && !pipeline_reset_busy |=> !load_clk;
    endproperty
    a_load_lo: assert property (p_load_lo) else $error("runt low");
    property p_prst;
        s_busy2 ##0 !load_clk |=> !load_clk;
    endproperty
    a_prst: assert property (p_prst) else $error("load during reset");
    property p_prst_end;
        $rose(pipeline_reset_busy) |-> ##[1:1000] !pipeline_reset_busy;
    endproperty
    a_prst_end: assert property (p_prst_end) else $error("reset stuck");
    property p_fb;
        fb_div_tick |=> !fb_div_tick;
    endproperty
    a_fb: assert property (p_fb) else $error("fb tick width");
    property p_ref;
        ref_div_tick |=> !ref_div_tick;
    endproperty
    a_ref: assert property (p_ref) else $error("ref tick width");
    property p_det;
        s_quiet |=> detector_enable;
    endproperty
    a_det: assert property (p_det) else $error("lock off");
endmodule
bind pcd_clock_divider_control pcd_chk u_chk (.pclk, .presetn, .psel, .penable, .paddr,
    .pready, .pslverr, .nibble_bus, .video_gate, .pixel_clk_p, .pixel_clk_n, .load_clk,
    .ref_div_tick, .fb_div_tick, .detector_enable, .pipeline_reset_busy);

// *** testbench/pcd_host_model.sv ***
// Purpose: host driving the nibble and serial programming pins
// Assumes: pins are synced by the block, so 6 pclk per phase
// Notes:   serial clock stands low between frames
`timescale 1ns/10ps
module pcd_host_model (
    input  wire logic       pclk,               // timing base
    output logic      [3:0] nibble_bus,         // nibble pins
    output logic            nibble_latch,       // strobe
    output logic            serial_shift_clock, // bit clock
    output logic            serial_data,        // bit
    output logic            transfer_hold       // transfer
);
    initial begin
        nibble_bus = 4'h0;
        nibble_latch = 1'b1;
        serial_shift_clock = 1'b0;
        serial_data = 1'b0;
        transfer_hold = 1'b0;
    end
    task wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task nib_write(input logic [3:0] a, input logic [3:0] d);
        nibble_bus <= a;
        wait_n(6);
        nibble_latch <= 1'b0;
        wait_n(6);
        nibble_bus <= d;
        wait_n(6);
        nibble_latch <= 1'b1;
        wait_n(6);
        nibble_bus <= ~d;
    endtask
    task ser_word(input logic [63:0] w, input logic hold);
        for (int i = 63; i >= 0; i--) begin
            serial_data <= w[i];
            transfer_hold <= hold && i == 0;
            wait_n(6);
            serial_shift_clock <= 1'b1;
            wait_n(6);
            serial_shift_clock <= 1'b0;
        end
        wait_n(6);
        serial_data <= !w[0];
        transfer_hold <= 1'b0;
        nibble_bus <= 4'h0;
    endtask
endmodule

// *** testbench/programmable_clock_divider_control_test.sv ***
// Purpose: self-checking bench of the divider control
// Assumes: apb answers with zero wait states
// Notes:   ref_clk_in runs at pclk/8
`timescale 1ns/10ps
`include "pcd_map.svh"
module programmable_clock_divider_control_test;
    logic        pclk, presetn, psel, penable, pwrite, video_gate, err;
    logic [2:0]  rc;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, pixel_clk_p, pixel_clk_n, load_clk, sec_o;
    logic        ref_div_tick, fb_div_tick, detector_enable, pipeline_reset_busy;
    logic [3:0]  nibble_bus;
    logic        nibble_latch, serial_shift_clock, serial_data, transfer_hold;
    int          fail_count, checks_done;
    int          mods [9] = '{3, 4, 5, 6, 8, 10, 12, 16, 20};
    logic [3:0]  cfg [16] = '{0, 0, 5, 2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    wire         ref_clk_in;
    assign ref_clk_in = rc[2];
    pcd_clock_divider_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .nibble_bus, .nibble_latch,
        .serial_shift_clock, .serial_data, .transfer_hold, .video_gate, .ref_clk_in,
        .pixel_clk_p, .pixel_clk_n, .load_clk, .secondary_divided_output(sec_o),
        .ref_div_tick, .fb_div_tick, .detector_enable, .pipeline_reset_busy);
    pcd_host_model host (.pclk, .nibble_bus, .nibble_latch, .serial_shift_clock,
        .serial_data, .transfer_hold);
    always #20 pclk = ~pclk;
    always @(posedge pclk) rc <= rc + 3'h1;
    ////////////////////////////////////////////////////////////////////////////////
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function logic pick(input int s);
        logic [4:0] v;
        v = {detector_enable, pipeline_reset_busy, sec_o, pixel_clk_p, load_clk};
        return v[s];
    endfunction
    task wait_for(input int s, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(s) !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // second period only: a change lands at a terminal count
    task measure(input int s, output int hi, output int per);
        repeat (2) begin
            wait_for(s, 1'b0, 400);
            wait_for(s, 1'b1, 400);
            hi = 0;
            per = 0;
            while (pick(s) === 1'b1 && per < 400) begin
                @(posedge pclk);
                hi++;
                per++;
            end
            while (pick(s) === 1'b0 && per > 0 && per < 400) begin
                @(posedge pclk);
                per++;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_por;
        int hi, per;
        measure(1, hi, per);
        check("pixel_per", per, 8);
        measure(0, hi, per);
        check("load_per", per, 8);
        apb(1'b0, 12'h008, 32'h0);
        check("slverr", err, 1);
    endtask
    task t_unlock;
        int hi, per;
        for (int r = 0; r < 16; r++) host.nib_write(4'(r), cfg[r]);
        repeat (15) host.nib_write(`PCD_REG_VOID_A, 4'h0);
        apb(1'b0, `PCD_ADDR_STATUS, 32'h0);
        check("count", rd[7:1], 31);
        measure(0, hi, per);
        check("locked_per", per, 8);
        host.nib_write(`PCD_REG_VOID_B, 4'h0);
        apb(1'b0, `PCD_ADDR_STATUS, 32'h0);
        check("unlock", rd[11:1], 32'h760);
        measure(0, hi, per);
        check("mod3_hi", hi, 3);
        check("mod3_per", per, 6);
    endtask
    task t_codes;
        int hi, per;
        for (int c = 0; c < 9; c++) begin
            host.nib_write(`PCD_REG_N1, 4'(c));
            measure(0, hi, per);
            check("n1_hi", hi, mods[c]);
            check("n1_per", per, 2 * mods[c]);
        end
        host.nib_write(`PCD_REG_N1, 4'h1);
        measure(1, hi, per);
        check("vco_per", per, 2);
        for (int p = 1; p < 3; p++) begin
            host.nib_write(`PCD_REG_POST, 4'(p));
            measure(0, hi, per);
            check("post_per", per, 8 << p);
        end
        host.nib_write(`PCD_REG_POST, 4'h8);
        measure(0, hi, per);
        check("vhalf_per", per, 4);
        host.nib_write(`PCD_REG_POST, 4'h7);
        repeat (10) @(posedge pclk);
        check("static_hi", pixel_clk_p, 1);
        host.nib_write(`PCD_REG_POST, 4'h3);
        check("static_lo", pixel_clk_p, 0);
        host.nib_write(`PCD_REG_POST, 4'h0);
        host.nib_write(`PCD_REG_CTL, 4'h1);
        measure(0, hi, per);
        check("n1_off", hi, 0);
    endtask
    task t_prst;
        repeat (`PCD_SETTLE_CYCLES) @(posedge pclk);
        host.nib_write(`PCD_REG_CTL, 4'h2);
        host.nib_write(`PCD_REG_CTL, 4'h0);
        wait_for(3, 1'b1, 200);
        check("prst_on", pipeline_reset_busy, 1);
        wait_for(3, 1'b0, 400);
        check("prst_off", pipeline_reset_busy, 0);
        host.nib_write(`PCD_REG_N1, 4'h6);
        host.nib_write(`PCD_REG_CTL, 4'h2);
        host.nib_write(`PCD_REG_CTL, 4'h0);
        wait_for(3, 1'b1, 200);
        check("prst_mod12", pipeline_reset_busy, 0);
    endtask
    task t_serial;
        int hi, per;
        apb(1'b1, `PCD_ADDR_CTRL, 32'h1);
        host.ser_word(64'h0300_2500, 1'b1);
        measure(0, hi, per);
        check("ser_per", per, 12);
        host.ser_word(64'h0000_2500, 1'b0);
        measure(0, hi, per);
        check("ser_hold", per, 12);
        host.ser_word(64'h4300_2500, 1'b1);
        video_gate <= 1'b1;
        wait_for(4, 1'b0, 20);
        check("det_off", detector_enable, 0);
        host.ser_word(64'h8300_2500, 1'b1);
        check("det_sc", detector_enable, 1);
        measure(2, hi, per);
        check("sec_run", per, 12);
        video_gate <= 1'b0;
        measure(2, hi, per);
        check("sec_stop", hi, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        fail_count = 0;
        checks_done = 0;
        pclk = 1'b0;
        rc = 3'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        video_gate = 1'b0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_por;
        t_unlock;
        t_codes;
        t_prst;
        t_serial;
        complete_run;
    end
    initial begin
        #(40 * 60000);
        fail_count++;
        complete_run;
    end
endmodule
